// ---- ppm_port_top.sv ----
// Port pin modes, port 3 latch and port 3 alternate functions
`timescale 1ns/1ps
module ppm_port_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Special function register access from the core
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // External memory selection and strobes
  input  wire logic        external_access_pin_n,
  input  wire logic        hardware_config_reg_one_mem_sel,
  input  wire logic        ext_mem_rd_n,
  input  wire logic        ext_mem_wr_n,
  input  wire logic [7:0]  port2_addr_hi,
  // Port 1 upper and port 2 latch values from the core
  input  wire logic [3:0]  port1_latch_upper,
  input  wire logic [7:0]  port2_latch,
  // Timer count inputs
  output logic             timer0_count_pulse,
  output logic             timer1_count_pulse,
  // External interrupt inputs
  input  wire logic        irq0_enable,
  input  wire logic        irq0_edge_mode,
  input  wire logic        irq1_enable,
  input  wire logic        irq1_edge_mode,
  output logic             ext_irq0_req,
  output logic             ext_irq1_req,
  // Serial port 0
  input  wire logic [1:0]  serial0_mode,
  input  wire logic        serial0_tx_data,
  input  wire logic        serial0_shift_clk,
  input  wire logic        serial0_rx_out,
  input  wire logic        serial0_rx_oe,
  output logic             serial0_rx_data,
  // Pads
  input  wire logic [7:0]  port3_pad_in,
  output logic      [7:0]  port3_pin_state,
  output logic      [19:0] pad_out,
  output logic      [19:0] pad_oe,
  output logic      [19:0] pad_pullup
);

  localparam int P2B = ppm_pkg::PIN_P2_BASE;
  localparam int P3B = ppm_pkg::PIN_P3_BASE;

  ppm_drv_if  #(.N(ppm_pkg::NUM_PINS)) drv_if ();
  ppm_sync_if #(.N(ppm_pkg::NUM_SYNC)) sync_if ();

  logic [7:0] p1_upper_q;
  logic [7:0] p2_lower_q;
  logic [7:0] p2_upper_q;
  logic [7:0] p3_lower_q;
  logic [7:0] p3_upper_q;
  logic [7:0] p3_latch_q;
  logic [7:0] sfr_rdata_q;
  logic       sfr_hit_q;
  logic       ext_irq0_q;
  logic       ext_irq1_q;
  logic       mode_written_q;
  logic       ext_mem;
  logic [7:0] p3_alt;
  logic [7:0] p3_data;
  logic [7:0] p3_force;
  logic       mapped;
  logic [7:0] rd_mux;

  // Register writes

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      p1_upper_q <= ppm_pkg::RST_PIN_MODES;
    else if (sfr_wr && sfr_addr == ppm_pkg::ADDR_P1_UPPER_MODES)
      p1_upper_q <= sfr_wdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      p2_lower_q <= ppm_pkg::RST_PIN_MODES;
    else if (sfr_wr && sfr_addr == ppm_pkg::ADDR_P2_LOWER_MODES)
      p2_lower_q <= sfr_wdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      p2_upper_q <= ppm_pkg::RST_PIN_MODES;
    else if (sfr_wr && sfr_addr == ppm_pkg::ADDR_P2_UPPER_MODES)
      p2_upper_q <= sfr_wdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      p3_lower_q <= ppm_pkg::RST_PIN_MODES;
    else if (sfr_wr && sfr_addr == ppm_pkg::ADDR_P3_LOWER_MODES)
      p3_lower_q <= sfr_wdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      p3_upper_q <= ppm_pkg::RST_PIN_MODES;
    else if (sfr_wr && sfr_addr == ppm_pkg::ADDR_P3_UPPER_MODES)
      p3_upper_q <= sfr_wdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      p3_latch_q <= ppm_pkg::RST_P3_LATCH;
    else if (sfr_wr && sfr_addr == ppm_pkg::ADDR_P3_LATCH)
      p3_latch_q <= sfr_wdata;
  end

  // Register reads, answered one cycle after the strobe

  always_comb
  begin
    mapped = 1'b1;
    unique case (sfr_addr)
      ppm_pkg::ADDR_P1_UPPER_MODES: rd_mux = p1_upper_q;
      ppm_pkg::ADDR_P3_LATCH:       rd_mux = p3_latch_q;
      ppm_pkg::ADDR_P2_LOWER_MODES: rd_mux = p2_lower_q;
      ppm_pkg::ADDR_P2_UPPER_MODES: rd_mux = p2_upper_q;
      ppm_pkg::ADDR_P3_LOWER_MODES: rd_mux = p3_lower_q;
      ppm_pkg::ADDR_P3_UPPER_MODES: rd_mux = p3_upper_q;
      default:
      begin
        rd_mux = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // The latch is returned, not the pins, so read-modify-write keeps intent
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end
    else
    begin
      sfr_rdata_q <= sfr_rd ? rd_mux : 8'h00;
      sfr_hit_q   <= sfr_rd & mapped;
    end
  end

  // External memory: access pin low or configuration select
  // The pin path is two cycles late through its synchroniser; the config bit acts at once
  assign ext_mem = ~sync_if.level[ppm_pkg::SYNC_EA_BIT]
                 | hardware_config_reg_one_mem_sel;

  // Port 3 alternate outputs; one means released to the latch
  always_comb
  begin
    p3_alt                      = 8'hff;
    p3_alt[ppm_pkg::P3_RD_BIT]  = ext_mem_rd_n;
    p3_alt[ppm_pkg::P3_WR_BIT]  = ext_mem_wr_n;
    p3_alt[ppm_pkg::P3_TX_BIT]  = (serial0_mode == ppm_pkg::SERIAL_MODE0)
                                ? serial0_shift_clk : serial0_tx_data;
    if (serial0_mode == ppm_pkg::SERIAL_MODE0 && serial0_rx_oe)
      p3_alt[ppm_pkg::P3_RX_BIT] = serial0_rx_out;
    p3_data  = p3_latch_q & p3_alt;
    p3_force = 8'h00;
    if (ext_mem)
    begin
      p3_data[ppm_pkg::P3_RD_BIT]  = ext_mem_rd_n;
      p3_data[ppm_pkg::P3_WR_BIT]  = ext_mem_wr_n;
      p3_force[ppm_pkg::P3_RD_BIT] = 1'b1;
      p3_force[ppm_pkg::P3_WR_BIT] = 1'b1;
    end
  end

  // Pin k of a half sits at bits 2k+1:2k, so halves concatenate in order
  assign drv_if.mode = {p3_upper_q, p3_lower_q, p2_upper_q,
                        p2_lower_q, p1_upper_q};
  assign drv_if.data = {p3_data,
                        ext_mem ? port2_addr_hi : port2_latch,
                        port1_latch_upper};
  assign drv_if.force_pp = {p3_force, {8{ext_mem}}, 4'h0};

  ppm_pin_drv #(.N(ppm_pkg::NUM_PINS)) u_pin_drv (
    .core_clk (core_clk),
    .rstn     (rstn),
    .d        (drv_if.drv)
  );

  assign sync_if.raw = {external_access_pin_n, port3_pad_in};

  ppm_in_sync #(.N(ppm_pkg::NUM_SYNC)) u_in_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .s        (sync_if.sync)
  );

  // External interrupt requests: pulse on falling edge, held high while the level is low
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_irq0_q <= 1'b0;
      ext_irq1_q <= 1'b0;
    end
    else
    begin
      ext_irq0_q <= irq0_enable & (irq0_edge_mode
                  ? sync_if.fall[ppm_pkg::P3_IX0_BIT]
                  : ~sync_if.level[ppm_pkg::P3_IX0_BIT]);
      ext_irq1_q <= irq1_enable & (irq1_edge_mode
                  ? sync_if.fall[ppm_pkg::P3_IX1_BIT]
                  : ~sync_if.level[ppm_pkg::P3_IX1_BIT]);
    end
  end

  // Seen by assertions only
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      mode_written_q <= 1'b0;
    else if (sfr_wr && sfr_addr != ppm_pkg::ADDR_P3_LATCH)
      mode_written_q <= 1'b1;
  end

  assign sfr_rdata          = sfr_rdata_q;
  assign sfr_hit            = sfr_hit_q;
  assign timer0_count_pulse = sync_if.fall[ppm_pkg::P3_T0_BIT];
  assign timer1_count_pulse = sync_if.fall[ppm_pkg::P3_T1_BIT];
  assign ext_irq0_req       = ext_irq0_q;
  assign ext_irq1_req       = ext_irq1_q;
  assign serial0_rx_data    = sync_if.level[ppm_pkg::P3_RX_BIT];
  assign port3_pin_state    = sync_if.level[7:0];
  assign pad_out            = drv_if.pad_out;
  assign pad_oe             = drv_if.pad_oe;
  assign pad_pullup         = drv_if.pad_pu;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_mode_reset_zero: assert property (
    !mode_written_q |-> (p1_upper_q == 8'h00 && p2_lower_q == 8'h00 && p2_upper_q == 8'h00
                         && p3_lower_q == 8'h00 && p3_upper_q == 8'h00))
    else $error("mode register not zero before any write");

  a_mode_readback: assert property (
    (sfr_wr && sfr_addr == ppm_pkg::ADDR_P3_UPPER_MODES)
    ##1 (sfr_rd && !sfr_wr && sfr_addr == ppm_pkg::ADDR_P3_UPPER_MODES)
    |=> (sfr_rdata == $past(sfr_wdata, 2) && sfr_hit))
    else $error("mode register did not read back written value");

  a_strobe_override: assert property (
    ext_mem |=> (pad_oe[P3B+7] && pad_out[P3B+7] == $past(ext_mem_rd_n)
                 && pad_oe[P3B+6] && pad_out[P3B+6] == $past(ext_mem_wr_n)))
    else $error("strobe pins not driven as strobes under external memory");

  a_port2_override: assert property (
    ext_mem |=> (pad_oe[P2B+7:P2B] == 8'hff && pad_out[P2B+7:P2B] == $past(port2_addr_hi)))
    else $error("port 2 not driving address under external memory");

  a_alt_gate_latch: assert property (
    (!p3_latch_q[ppm_pkg::P3_TX_BIT] && p3_lower_q[3:2] == ppm_pkg::PPM_PUSH_PULL)
    |=> (pad_oe[P3B+1] && !pad_out[P3B+1]))
    else $error("alternate function leaked through a zero latch bit");

  a_serial_clock: assert property (
    (p3_latch_q[ppm_pkg::P3_TX_BIT] && serial0_mode == ppm_pkg::SERIAL_MODE0
     && p3_lower_q[3:2] == ppm_pkg::PPM_PUSH_PULL)
    |=> pad_out[P3B+1] == $past(serial0_shift_clk))
    else $error("shift clock not on transmit pin in mode 0");

  a_irq_level: assert property (
    (irq1_enable && !irq1_edge_mode)
    |=> ext_irq1_req == !$past(sync_if.level[ppm_pkg::P3_IX1_BIT]))
    else $error("level interrupt 1 request wrong");

  a_irq_disabled: assert property (
    !irq0_enable |=> !ext_irq0_req)
    else $error("interrupt 0 raised while disabled");

  a_irq1_edge: assert property (
    (irq1_enable && irq1_edge_mode && sync_if.fall[ppm_pkg::P3_IX1_BIT]) |=> ext_irq1_req)
    else $error("edge interrupt 1 request missing");

  a_irq0_edge: assert property (
    (irq0_enable && irq0_edge_mode && sync_if.fall[ppm_pkg::P3_IX0_BIT]) |=> ext_irq0_req)
    else $error("edge interrupt 0 request missing");

  a_rdata_idle: assert property (
    !sfr_rd |=> (sfr_rdata == 8'h00 && !sfr_hit))
    else $error("read data not idle without a read");

  c_mode_write: cover property (sfr_wr && sfr_addr == ppm_pkg::ADDR_P2_LOWER_MODES);
  c_ext_strobe: cover property (ext_mem && !p3_latch_q[ppm_pkg::P3_WR_BIT] ##1 !pad_out[P3B+6]);
  c_timer_count: cover property (timer1_count_pulse);
  c_irq_edge: cover property (irq0_edge_mode && ext_irq0_req);
  c_rx_drive: cover property (serial0_mode == ppm_pkg::SERIAL_MODE0 && serial0_rx_oe);

endmodule : ppm_port_top

// ---- ppm_pkg.sv ----
// Constants and types for the port pin mode and alternate function block
package ppm_pkg;

  localparam logic [7:0] ADDR_P1_UPPER_MODES = 8'haf;
  localparam logic [7:0] ADDR_P3_LATCH       = 8'hb0;
  localparam logic [7:0] ADDR_P2_LOWER_MODES = 8'hb1;
  localparam logic [7:0] ADDR_P2_UPPER_MODES = 8'hb2;
  localparam logic [7:0] ADDR_P3_LOWER_MODES = 8'hb3;
  localparam logic [7:0] ADDR_P3_UPPER_MODES = 8'hb4;

  localparam logic [7:0] RST_PIN_MODES = 8'h00;
  localparam logic [7:0] RST_P3_LATCH  = 8'hff;

  typedef enum logic [1:0] {
    PPM_QUASI      = 2'b00,
    PPM_PUSH_PULL  = 2'b01,
    PPM_OPEN_DRAIN = 2'b10,
    PPM_INPUT_ONLY = 2'b11
  } ppm_mode_t;

  // Port 3 bit positions
  localparam int P3_RD_BIT  = 7;
  localparam int P3_WR_BIT  = 6;
  localparam int P3_T1_BIT  = 5;
  localparam int P3_T0_BIT  = 4;
  localparam int P3_IX1_BIT = 3;
  localparam int P3_IX0_BIT = 2;
  localparam int P3_TX_BIT  = 1;
  localparam int P3_RX_BIT  = 0;

  // Pad vector layout: port 1 pins 4..7, port 2, port 3
  localparam int NUM_PINS    = 20;
  localparam int PIN_P1_BASE = 0;
  localparam int PIN_P2_BASE = 4;
  localparam int PIN_P3_BASE = 12;

  // Synchroniser layout: port 3 pins, then the access pin
  localparam int NUM_SYNC   = 9;
  localparam int SYNC_EA_BIT = 8;

  localparam logic [1:0] SERIAL_MODE0 = 2'b00;

endpackage : ppm_pkg

// ---- ppm_ifs.sv ----
// Carriers between the port block and its pin driver and synchroniser
`timescale 1ns/1ps
interface ppm_drv_if #(parameter int N = 20);
  logic [2*N-1:0] mode;
  logic [N-1:0]   data;
  logic [N-1:0]   force_pp;
  logic [N-1:0]   pad_out;
  logic [N-1:0]   pad_oe;
  logic [N-1:0]   pad_pu;
  modport ctrl (output mode, output data, output force_pp,
                input pad_out, input pad_oe, input pad_pu);
  modport drv  (input mode, input data, input force_pp,
                output pad_out, output pad_oe, output pad_pu);
endinterface : ppm_drv_if

interface ppm_sync_if #(parameter int N = 9);
  logic [N-1:0] raw;
  logic [N-1:0] level;
  logic [N-1:0] fall;
  modport ctrl (output raw, input level, input fall);
  modport sync (input raw, output level, output fall);
endinterface : ppm_sync_if

// ---- ppm_pin_drv.sv ----
// Registered per-pin driver decoding the two-bit pin mode
`timescale 1ns/1ps
module ppm_pin_drv #(
  parameter int N = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Mode, data and pad controls
  ppm_drv_if.drv   d
);

  if (N < 1) $error("ppm_pin_drv: N must be at least 1");

  for (genvar i = 0; i < N; i++) begin : g_pin
    ppm_pkg::ppm_mode_t m;
    logic [2:0]         nxt;

    always_comb
    begin
      m = ppm_pkg::ppm_mode_t'(d.mode[2*i +: 2]);
      if (d.force_pp[i])
        nxt = {d.data[i], 1'b1, 1'b0};
      else
      begin
        unique case (m)
          ppm_pkg::PPM_QUASI:      nxt = {1'b0, ~d.data[i], d.data[i]};
          ppm_pkg::PPM_PUSH_PULL:  nxt = {d.data[i], 1'b1, 1'b0};
          ppm_pkg::PPM_OPEN_DRAIN: nxt = {1'b0, ~d.data[i], 1'b0};
          ppm_pkg::PPM_INPUT_ONLY: nxt = 3'b000;
        endcase
      end
    end

    // Registered so a mode write reaches the pad one cycle later
    always_ff @(posedge core_clk or negedge rstn)
    begin
      if (!rstn)
        {d.pad_out[i], d.pad_oe[i], d.pad_pu[i]} <= 3'b001;
      else
        {d.pad_out[i], d.pad_oe[i], d.pad_pu[i]} <= nxt;
    end

    a_pushpull_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      ($past(rstn) && !$past(d.force_pp[i])
       && $past(d.mode[2*i +: 2]) == ppm_pkg::PPM_PUSH_PULL)
      |-> (d.pad_oe[i] && d.pad_out[i] == $past(d.data[i]) && !d.pad_pu[i]))
      else $error("push-pull pin not driving its data");
    a_opendrain_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      ($past(rstn) && !$past(d.force_pp[i])
       && $past(d.mode[2*i +: 2]) == ppm_pkg::PPM_OPEN_DRAIN)
      |-> (!d.pad_out[i] && d.pad_oe[i] == !$past(d.data[i]) && !d.pad_pu[i]))
      else $error("open-drain pin drives high or misses low");
    a_input_float: assert property (@(posedge core_clk) disable iff (!rstn)
      ($past(rstn) && !$past(d.force_pp[i])
       && $past(d.mode[2*i +: 2]) == ppm_pkg::PPM_INPUT_ONLY)
      |-> (!d.pad_oe[i] && !d.pad_pu[i]))
      else $error("input-only pin is driven");
    a_quasi_weak: assert property (@(posedge core_clk) disable iff (!rstn)
      ($past(rstn) && !$past(d.force_pp[i])
       && $past(d.mode[2*i +: 2]) == ppm_pkg::PPM_QUASI)
      |-> (d.pad_pu[i] == $past(d.data[i]) && d.pad_oe[i] == !$past(d.data[i])))
      else $error("quasi pin pull-up or low drive wrong");
  end

endmodule : ppm_pin_drv

// ---- ppm_in_sync.sv ----
// Two-stage synchroniser with registered falling-edge detect
`timescale 1ns/1ps
module ppm_in_sync #(
  parameter int N = 9
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Raw pins in, clean levels and edges out
  ppm_sync_if.sync s
);

  if (N < 1) $error("ppm_in_sync: N must be at least 1");

  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] fall_q;

  // Idle high so no false edge appears at reset release
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end
    else
    begin
      s1_q <= s.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      fall_q <= '0;
    else
      fall_q <= s3_q & ~s2_q;
  end

  assign s.level = s2_q;
  assign s.fall  = fall_q;

  for (genvar i = 0; i < N; i++) begin : g_chk
    a_fall_detect: assert property (@(posedge core_clk) disable iff (!rstn)
      (s.raw[i] [*3] ##1 !s.raw[i] [*3]) |-> ##[0:4] s.fall[i])
      else $error("falling edge on pin not reported");
  end

endmodule : ppm_in_sync

// ---- ppm_board_model.sv ----
// Board-side model of the port 3 pins: pad drivers, pull-ups and signal sources
`timescale 1ns/1ps
module ppm_board_model (
  // Clock
  input  wire logic       core_clk,
  // Port 3 pad controls
  input  wire logic [7:0] p3_out,
  input  wire logic [7:0] p3_oe,
  input  wire logic [7:0] p3_pu,
  // Board signal sources
  input  wire logic [7:0] src_en,
  input  wire logic [7:0] src_val,
  // Resolved pin levels
  output logic      [7:0] pin_lvl
);
  logic [7:0] last_q;

  always_ff @(posedge core_clk)
    last_q <= pin_lvl;

  // A floating pin flips every cycle, so a missing drive never reads as steady
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (p3_oe[i])
        pin_lvl[i] = p3_out[i];
      else if (src_en[i])
        pin_lvl[i] = src_val[i];
      else if (p3_pu[i])
        pin_lvl[i] = 1'b1;
      else
        pin_lvl[i] = ~last_q[i];
    end
  end
endmodule : ppm_board_model

// ---- tb_top.sv ----
// Self-checking testbench for the port pin mode block
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_rdata, port3_pin_state, port3_pad_in;
  logic        sfr_hit, timer0_count_pulse, timer1_count_pulse;
  logic        ext_irq0_req, ext_irq1_req, serial0_rx_data;
  logic [19:0] pad_out, pad_oe, pad_pullup;
  logic        external_access_pin_n = 1'b1;
  logic        hardware_config_reg_one_mem_sel = 1'b0;
  logic        ext_mem_rd_n = 1'b1;
  logic        ext_mem_wr_n = 1'b1;
  logic [7:0]  port2_addr_hi = 8'h00;
  logic [7:0]  port2_latch = 8'h00;
  logic [3:0]  port1_latch_upper = 4'h0;
  logic        irq0_enable = 1'b1;
  logic        irq0_edge_mode = 1'b1;
  logic        irq1_enable = 1'b1;
  logic        irq1_edge_mode = 1'b1;
  logic [1:0]  serial0_mode = 2'b01;
  logic        serial0_tx_data = 1'b1;
  logic        serial0_shift_clk = 1'b1;
  logic        serial0_rx_out = 1'b1;
  logic        serial0_rx_oe = 1'b0;
  logic [7:0]  src_en = 8'h00;
  logic [7:0]  src_val = 8'hff;
  logic [7:0]  regv [6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  adr [6] = '{ppm_pkg::ADDR_P1_UPPER_MODES, ppm_pkg::ADDR_P3_LATCH,
                           ppm_pkg::ADDR_P2_LOWER_MODES, ppm_pkg::ADDR_P2_UPPER_MODES,
                           ppm_pkg::ADDR_P3_LOWER_MODES, ppm_pkg::ADDR_P3_UPPER_MODES};
  int          pc [4];
  int          pb [4];
  int          n_errors = 0;
  int          num_checks = 0;

  always #5 core_clk = ~core_clk;

  ppm_port_top uut (.core_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
    .sfr_hit, .external_access_pin_n, .hardware_config_reg_one_mem_sel, .ext_mem_rd_n,
    .ext_mem_wr_n, .port2_addr_hi, .port1_latch_upper, .port2_latch, .timer0_count_pulse,
    .timer1_count_pulse, .irq0_enable, .irq0_edge_mode, .irq1_enable, .irq1_edge_mode,
    .ext_irq0_req, .ext_irq1_req, .serial0_mode, .serial0_tx_data, .serial0_shift_clk,
    .serial0_rx_out, .serial0_rx_oe, .serial0_rx_data, .port3_pad_in, .port3_pin_state,
    .pad_out, .pad_oe, .pad_pullup);

  ppm_board_model board (.core_clk, .p3_out(pad_out[19:12]), .p3_oe(pad_oe[19:12]),
    .p3_pu(pad_pullup[19:12]), .src_en, .src_val, .pin_lvl(port3_pad_in));

  // Pulse counters: irq0, irq1, timer0, timer1; read mid-cycle, away from the launch edge
  always @(negedge core_clk)
  begin
    pc[0] += ext_irq0_req;
    pc[1] += ext_irq1_req;
    pc[2] += timer0_count_pulse;
    pc[3] += timer1_count_pulse;
  end

  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(int r, logic [7:0] d);
    regv[r] = d;
    @(posedge core_clk);
    sfr_addr <= adr[r];
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(logic [7:0] a, logic [7:0] exp, logic hit);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    chk("sfr_rdata", sfr_rdata, exp);
    chk("sfr_hit", sfr_hit, hit);
  endtask : rd_chk

  // Expected pad controls worked out from the stored register images
  task automatic pads_chk();
    logic [1:0] m;
    logic       d;
    int         g;
    for (int i = 0; i < 20; i++)
    begin
      g = i < 4 ? 0 : (i < 12 ? 2 + (i - 4) / 4 : 4 + (i - 12) / 4);
      m = regv[g][2*(i%4)+:2];
      d = i < 4 ? port1_latch_upper[i] : (i < 12 ? port2_latch[i-4] : regv[1][i-12]);
      chk("pad_oe", pad_oe[i], m == 2'b01 || (!m[0] && !d));
      chk("pad_out", pad_out[i], m == 2'b01 && d);
      chk("pad_pullup", pad_pullup[i], m == 2'b00 && d);
    end
  endtask : pads_chk

  task automatic fall(int p);
    pb = pc;
    @(posedge core_clk);
    src_val[p] <= 1'b0;
    repeat (6) @(posedge core_clk);
    src_val[p] <= 1'b1;
    cyc(6);
  endtask : fall

  // Pulses since the last fall, weighted per counter
  function automatic int pulses();
    return (pc[0] - pb[0]) + 4 * (pc[1] - pb[1]) + 16 * (pc[2] - pb[2]) + 64 * (pc[3] - pb[3]);
  endfunction : pulses

  initial
  begin
    #200_000;
    n_errors++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    void'($urandom(26535));
    cyc(3);
    pads_chk();
    for (int r = 0; r < 6; r++)
      rd_chk(adr[r], regv[r], 1'b1);
    rd_chk(8'hb5, 8'h00, 1'b0);
    // Random modes and latches, every register read back
    repeat (10)
    begin
      for (int r = 0; r < 6; r++)
        wr(r, 8'($urandom));
      port1_latch_upper <= 4'($urandom);
      port2_latch <= 8'($urandom);
      for (int r = 0; r < 6; r++)
        rd_chk(adr[r], regv[r], 1'b1);
      cyc(2);
      pads_chk();
    end
    // Write then read in the very next cycle
    @(posedge core_clk);
    regv[5] = 8'($urandom);
    sfr_addr <= adr[5];
    sfr_wdata <= regv[5];
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    chk("b2b_rdata", sfr_rdata, regv[5]);
    // Strobes and port 2 under external memory, by config bit then by access pin
    wr(1, 8'h3f);
    wr(5, 8'hff);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      port2_addr_hi <= 8'($urandom);
      hardware_config_reg_one_mem_sel <= !k[1];
      external_access_pin_n <= !k[1];
      ext_mem_wr_n <= k[0];
      ext_mem_rd_n <= !k[0];
      cyc(5);
      chk("p2_oe", pad_oe[11:4], 8'hff);
      chk("p2_out", pad_out[11:4], port2_addr_hi);
      chk("strobe_oe", pad_oe[19:18], 2'b11);
      chk("strobe_out", pad_out[19:18], {!k[0], k[0]});
    end
    @(posedge core_clk);
    external_access_pin_n <= 1'b1;
    ext_mem_rd_n <= 1'b1;
    ext_mem_wr_n <= 1'b1;
    cyc(5);
    chk("strobe_released", pad_oe[19:18], 2'b00);
    // Transmit pin: latch low wins, then data or shift clock by serial mode
    wr(4, 8'h55);
    wr(1, 8'hfd);
    cyc(2);
    chk("tx_latch_low", pad_out[13], 1'b0);
    wr(1, 8'hff);
    for (int t = 0; t < 4; t++)
    begin
      @(posedge core_clk);
      serial0_mode <= t[1] ? 2'b00 : 2'b01;
      serial0_shift_clk <= t[0];
      serial0_tx_data <= !t[0];
      serial0_rx_oe <= 1'b1;
      serial0_rx_out <= !t[0];
      cyc(2);
      chk("tx_pin", pad_out[13], t[1] ? t[0] : !t[0]);
      chk("rx_pin", pad_out[12], t[1] ? !t[0] : 1'b1);
    end
    // Input pins: receive level, timer counts and interrupts
    @(posedge core_clk);
    serial0_mode <= 2'b01;
    src_en <= 8'h3f;
    wr(4, 8'hff);
    wr(5, 8'hff);
    cyc(6);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge core_clk);
      src_val[0] <= v[0];
      cyc(4);
      chk("rx_data", serial0_rx_data, v[0]);
      chk("pin_state", port3_pin_state[5:0], src_val[5:0]);
    end
    for (int p = 2; p < 6; p++)
    begin
      fall(p);
      chk("pulses", pulses(), 1 << (2 * (p - 2)));
    end
    @(posedge core_clk);
    irq0_enable <= 1'b0;
    irq1_enable <= 1'b0;
    for (int p = 2; p < 4; p++)
    begin
      fall(p);
      chk("irq_masked", pulses(), 0);
    end
    @(posedge core_clk);
    irq0_enable <= 1'b1;
    irq1_enable <= 1'b1;
    irq0_edge_mode <= 1'b0;
    irq1_edge_mode <= 1'b0;
    src_val <= 8'hf3;
    cyc(6);
    chk("irq_level", {ext_irq1_req, ext_irq0_req}, 2'b11);
    @(posedge core_clk);
    src_val <= 8'hff;
    cyc(6);
    chk("irq_level_off", {ext_irq1_req, ext_irq0_req}, 2'b00);
    stop_test();
  end
endmodule : tb_top
